//--- rtl/cprs_params.svh
`ifndef CPRS_PARAMS_SVH
`define CPRS_PARAMS_SVH

`define CPRS_XLEN      32
`define CPRS_PC_MSB    25
`define CPRS_STATUS_MSB 7
`define CPRS_ZERO_IDX  5'h00
`define CPRS_EP_IDX    5'h1E
`define CPRS_NUM_REGS  32

`define CPRS_SR_INT_PC    5'h00
`define CPRS_SR_INT_ST    5'h01
`define CPRS_SR_NMI_PC    5'h02
`define CPRS_SR_NMI_ST    5'h03
`define CPRS_SR_CAUSE     5'h04
`define CPRS_SR_STATUS    5'h05
`define CPRS_SR_TBL_PC    5'h10
`define CPRS_SR_TBL_ST    5'h11
`define CPRS_SR_DBG_PC    5'h12
`define CPRS_SR_DBG_ST    5'h13
`define CPRS_SR_TBL_BASE  5'h14

`define CPRS_GPR_RST   32'h0000_0000
`define CPRS_PC_RST    32'h0000_0000
`define CPRS_SR_RST    32'h0000_0000
`define CPRS_STATUS_RST 32'h0000_0020

`endif

//--- rtl/cprs_pkg.sv
`include "cprs_params.svh"

package cprs_pkg;

  typedef logic [`CPRS_XLEN-1:0] cprs_word_t;
  typedef logic [4:0]            cprs_idx_t;

  typedef enum logic [4:0] {
    CPRS_SR_INT_PC   = `CPRS_SR_INT_PC,
    CPRS_SR_INT_ST   = `CPRS_SR_INT_ST,
    CPRS_SR_NMI_PC   = `CPRS_SR_NMI_PC,
    CPRS_SR_NMI_ST   = `CPRS_SR_NMI_ST,
    CPRS_SR_CAUSE    = `CPRS_SR_CAUSE,
    CPRS_SR_STATUS   = `CPRS_SR_STATUS,
    CPRS_SR_TBL_PC   = `CPRS_SR_TBL_PC,
    CPRS_SR_TBL_ST   = `CPRS_SR_TBL_ST,
    CPRS_SR_DBG_PC   = `CPRS_SR_DBG_PC,
    CPRS_SR_DBG_ST   = `CPRS_SR_DBG_ST,
    CPRS_SR_TBL_BASE = `CPRS_SR_TBL_BASE
  } cprs_sysreg_e;

  // Program counter form: upper bits and bit 0 forced low
  function automatic cprs_word_t cprs_pc_fix(input cprs_word_t v);
    cprs_word_t r;
    r = '0;
    r[`CPRS_PC_MSB:1] = v[`CPRS_PC_MSB:1];
    return r;
  endfunction

  // Saved-PC form keeps bit 0; return path drops it later
  function automatic cprs_word_t cprs_pcsave_fix(input cprs_word_t v);
    cprs_word_t r;
    r = '0;
    r[`CPRS_PC_MSB:0] = v[`CPRS_PC_MSB:0];
    return r;
  endfunction

  function automatic cprs_word_t cprs_status_fix(input cprs_word_t v);
    cprs_word_t r;
    r = '0;
    r[`CPRS_STATUS_MSB:0] = v[`CPRS_STATUS_MSB:0];
    return r;
  endfunction

endpackage

//--- rtl/cprs_sysreg_file.sv
`timescale 1ns/1ps
`include "cprs_params.svh"

module cprs_sysreg_file (
  input  wire logic               core_clk,   // Core clock
  input  wire logic               srst,       // Sync reset
  input  wire logic               clkEn,      // Freeze when low
  input  wire logic               debugMode,  // Debug trap window
  input  wire logic               wrEn,       // Load-system-register
  input  wire cprs_pkg::cprs_idx_t wrNum,     // Write number
  input  wire cprs_pkg::cprs_word_t wrData,   // Write value
  input  wire logic               rdEn,       // Store-system-register
  input  wire cprs_pkg::cprs_idx_t rdNum,     // Read number
  output cprs_pkg::cprs_word_t    rdData,     // Read value
  input  wire logic               causeLoadEn,  // Cause capture
  input  wire cprs_pkg::cprs_word_t causeLoadVal, // Cause code
  output cprs_pkg::cprs_word_t    statusWord, // Live status word
  output logic                    intAckHold  // Hold interrupt ack
);
  import cprs_pkg::*;

  cprs_word_t srFile [0:`CPRS_NUM_REGS-1];                 // [RULE2]

  function automatic logic srReachable(input cprs_idx_t n,
                                       input logic dbg);
    case (n)
      CPRS_SR_INT_PC, CPRS_SR_INT_ST, CPRS_SR_NMI_PC, CPRS_SR_NMI_ST,
      CPRS_SR_CAUSE, CPRS_SR_STATUS, CPRS_SR_TBL_PC, CPRS_SR_TBL_ST,
      CPRS_SR_TBL_BASE: srReachable = 1'b1;
      CPRS_SR_DBG_PC, CPRS_SR_DBG_ST: srReachable = dbg;
      default: srReachable = 1'b0;
    endcase
  endfunction

  function automatic cprs_word_t srFix(input cprs_idx_t n,
                                       input cprs_word_t v);
    case (n)
      CPRS_SR_INT_PC, CPRS_SR_NMI_PC, CPRS_SR_TBL_PC, CPRS_SR_DBG_PC:
        srFix = cprs_pcsave_fix(v);
      CPRS_SR_INT_ST, CPRS_SR_NMI_ST, CPRS_SR_STATUS, CPRS_SR_TBL_ST,
      CPRS_SR_DBG_ST: srFix = cprs_status_fix(v);
      default: srFix = v;
    endcase
  endfunction

  logic srWrOk;
  assign srWrOk = wrEn && srReachable(wrNum, debugMode)
                  && (wrNum != CPRS_SR_CAUSE);                // [RULE11]

  ////////////////////////////////////////////////////////////////////////
  // Storage; cause capture wins over a same-cycle software write
  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < `CPRS_NUM_REGS; i++) begin
        srFile[i] <= `CPRS_SR_RST;
      end
      srFile[CPRS_SR_STATUS] <= `CPRS_STATUS_RST;
    end else if (clkEn) begin
      if (srWrOk) begin
        srFile[wrNum] <= srFix(wrNum, wrData);           // [RULE8] [RULE9]
      end
      if (causeLoadEn) begin
        srFile[CPRS_SR_CAUSE] <= causeLoadVal;
      end
    end
  end

  assign statusWord = srFile[CPRS_SR_STATUS];              // [RULE12]

  // Reserved numbers read zero rather than stale array contents
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdData <= `CPRS_SR_RST;
    end else if (clkEn && rdEn) begin
      rdData <= srReachable(rdNum, debugMode) ? srFile[rdNum]
                                              : `CPRS_SR_RST; // [RULE10]
    end
  end

  // One-cycle hold rises on the edge where the new word lands
  always_ff @(posedge core_clk) begin
    if (srst) begin
      intAckHold <= 1'b0;
    end else if (clkEn) begin
      intAckHold <= srWrOk && (wrNum == CPRS_SR_STATUS);    // [RULE12]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  a_cause_read_only: assert property ( // [RULE11]
    @(posedge core_clk) disable iff (srst)
    clkEn && wrEn && wrNum == CPRS_SR_CAUSE && !causeLoadEn
    |=> srFile[CPRS_SR_CAUSE] == $past(srFile[CPRS_SR_CAUSE]))
    else $error("Cause register changed by software write");

  a_status_write_hold: assert property ( // [RULE12]
    @(posedge core_clk) disable iff (srst)
    clkEn && wrEn && wrNum == CPRS_SR_STATUS
    |=> intAckHold && statusWord == cprs_status_fix($past(wrData)))
    else $error("Status word write not applied with ack hold");

  a_sr_reserved_zero: assert property ( // [RULE10]
    @(posedge core_clk) disable iff (srst)
    clkEn && rdEn && (rdNum > CPRS_SR_STATUS) && (rdNum < CPRS_SR_TBL_PC)
    |=> rdData == '0)
    else $error("Reserved system register number read nonzero");

endmodule

//--- rtl/cprs_regs.sv
// What this block does
// [RULE1] Thirty-two 32-bit general registers, usable as data or address.
// [RULE2] Every program and system register is 32 bits wide.
// [RULE3] Reading general register zero always returns zero.
// [RULE4] Short loads and stores take register thirty as their base address.
// [RULE5] Program counter keeps 26 low bits; bits 31 to 26 read zero.
// [RULE6] Carry out of program counter bit 25 is dropped.
// [RULE7] Program counter bit zero is always zero.
// [RULE8] System registers reached only by numbered system load/store.
// [RULE9] Numbers 0-5 and 16-20 select the listed system registers in order.
// [RULE10] Software must avoid reserved numbers 6-15 and 21-31.
// [RULE11] Cause register is read-only; system loads to it are ignored.
// [RULE12] Status load applies on completion; interrupt ack held meanwhile.
// [RULE13] Writes to register zero are dropped; others update at the edge.
`timescale 1ns/1ps
`include "cprs_params.svh"

module cprs_regs (
  input  wire logic                 core_clk,    // 25 MHz core clock
  input  wire logic                 srst,        // Sync reset, high
  input  wire logic                 clkEn,       // Freeze when low
  input  wire cprs_pkg::cprs_idx_t  rdAddrA,     // Read port A index
  output cprs_pkg::cprs_word_t      rdDataA,     // Read port A data
  input  wire cprs_pkg::cprs_idx_t  rdAddrB,     // Read port B index
  output cprs_pkg::cprs_word_t      rdDataB,     // Read port B data
  input  wire logic                 wrEn,        // Write strobe
  input  wire cprs_pkg::cprs_idx_t  wrAddr,      // Write index
  input  wire cprs_pkg::cprs_word_t wrData,      // Write value
  input  wire logic                 shortAccess, // Short load/store
  input  wire logic [7:0]           shortDisp,   // Short displacement
  output cprs_pkg::cprs_word_t      shortAddr,   // Short access addr
  output cprs_pkg::cprs_word_t      epBase,      // Element pointer
  input  wire logic                 pcLoad,      // Branch or return
  input  wire cprs_pkg::cprs_word_t pcTarget,    // Branch target
  input  wire logic                 pcAdv,       // Advance PC
  input  wire cprs_pkg::cprs_word_t pcStep,      // Advance amount
  output cprs_pkg::cprs_word_t      pc,          // Program counter
  input  wire logic                 debugMode,   // Debug trap window
  input  wire logic                 srWrEn,      // Load-system-reg
  input  wire cprs_pkg::cprs_idx_t  srWrNum,     // System reg number
  input  wire cprs_pkg::cprs_word_t srWrData,    // System reg value
  input  wire logic                 srRdEn,      // Store-system-reg
  input  wire cprs_pkg::cprs_idx_t  srRdNum,     // System reg number
  output cprs_pkg::cprs_word_t      srRdData,    // System reg value
  input  wire logic                 causeLoadEn,  // Cause capture
  input  wire cprs_pkg::cprs_word_t causeLoadVal, // Cause code
  output cprs_pkg::cprs_word_t      statusWord,  // Status word
  output logic                      intAckHold   // Hold interrupt ack
);
  import cprs_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // General registers; entry zero is never written
  cprs_word_t gpr [0:`CPRS_NUM_REGS-1];                      // [RULE1]

  logic gprWrOk;
  assign gprWrOk = wrEn && (wrAddr != `CPRS_ZERO_IDX);       // [RULE13]

  // Read view with same-cycle write forwarded; zero index wins
  function automatic cprs_word_t gprView(input cprs_idx_t a,
                                         input logic we,
                                         input cprs_idx_t wa,
                                         input cprs_word_t wd,
                                         input cprs_word_t cur);
    if (a == `CPRS_ZERO_IDX) begin
      gprView = `CPRS_GPR_RST;                                // [RULE3]
    end else if (we && wa == a) begin
      gprView = wd;
    end else begin
      gprView = cur;
    end
  endfunction

  always_ff @(posedge core_clk) begin
    if (srst) begin
      for (int i = 0; i < `CPRS_NUM_REGS; i++) begin
        gpr[i] <= `CPRS_GPR_RST;
      end
    end else if (clkEn && gprWrOk) begin
      gpr[wrAddr] <= wrData;                                  // [RULE13]
    end
  end

  // Registered reads keep every output on a flop
  always_ff @(posedge core_clk) begin
    if (srst) begin
      rdDataA <= `CPRS_GPR_RST;
      rdDataB <= `CPRS_GPR_RST;
    end else if (clkEn) begin
      rdDataA <= gprView(rdAddrA, gprWrOk, wrAddr, wrData,
                         gpr[rdAddrA]);                       // [RULE3]
      rdDataB <= gprView(rdAddrB, gprWrOk, wrAddr, wrData,
                         gpr[rdAddrB]);                       // [RULE3]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Element pointer mirror and short-format address
  always_ff @(posedge core_clk) begin
    if (srst) begin
      epBase <= `CPRS_GPR_RST;
    end else if (clkEn && gprWrOk && wrAddr == `CPRS_EP_IDX) begin
      epBase <= wrData;
    end
  end

  // Base is the pointer before any same-cycle write, as in a pipeline
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shortAddr <= `CPRS_GPR_RST;
    end else if (clkEn && shortAccess) begin
      shortAddr <= gpr[`CPRS_EP_IDX] + {24'h00_0000, shortDisp}; // [RULE4]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Program counter; a load outranks an advance
  cprs_word_t next_pc;

  always_comb begin
    next_pc = pc;
    if (pcLoad) begin
      next_pc = cprs_pc_fix(pcTarget);                     // [RULE5] [RULE7]
    end else if (pcAdv) begin
      // Sum beyond bit 25 is cut by the fix, never reaching bit 26
      next_pc = cprs_pc_fix(pc + pcStep);                  // [RULE6]
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pc <= `CPRS_PC_RST;
    end else if (clkEn) begin
      pc <= next_pc;                                       // [RULE5]
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // System registers, reached only through the numbered port
  cprs_sysreg_file u_sysreg (
    .core_clk   (core_clk),
    .srst       (srst),
    .clkEn      (clkEn),
    .debugMode  (debugMode),
    .wrEn       (srWrEn),                                  // [RULE8]
    .wrNum      (srWrNum),
    .wrData     (srWrData),
    .rdEn       (srRdEn),                                  // [RULE8]
    .rdNum      (srRdNum),
    .rdData     (srRdData),
    .causeLoadEn  (causeLoadEn),
    .causeLoadVal (causeLoadVal),
    .statusWord (statusWord),
    .intAckHold (intAckHold)
  );

  ////////////////////////////////////////////////////////////////////////
  a_zero_read_a: assert property ( // [RULE3]
    @(posedge core_clk) disable iff (srst)
    clkEn && rdAddrA == `CPRS_ZERO_IDX |=> rdDataA == '0)
    else $error("Register zero read nonzero on port A");

  a_zero_write_drop: assert property ( // [RULE13]
    @(posedge core_clk) disable iff (srst)
    clkEn && wrEn && wrAddr == `CPRS_ZERO_IDX
          && rdAddrB == `CPRS_ZERO_IDX
    |=> rdDataB == '0 ##1 gpr[0] == '0)
    else $error("Write to register zero took effect");

  a_gpr_write_fwd: assert property ( // [RULE13]
    @(posedge core_clk) disable iff (srst)
    clkEn && wrEn && wrAddr != `CPRS_ZERO_IDX && rdAddrA == wrAddr
    |=> rdDataA == $past(wrData) && gpr[$past(wrAddr)] == rdDataA)
    else $error("Written value not seen at next read");

  a_ep_short_base: assert property ( // [RULE4]
    @(posedge core_clk) disable iff (srst)
    clkEn && shortAccess
    |=> shortAddr == $past(epBase) + {24'h00_0000, $past(shortDisp)})
    else $error("Short access not based on element pointer");

  a_pc_upper_zero: assert property ( // [RULE5]
    @(posedge core_clk) disable iff (srst)
    pc[31:26] == 6'h00)
    else $error("Program counter upper bits nonzero");

  a_pc_bit0_zero: assert property ( // [RULE7]
    @(posedge core_clk) disable iff (srst)
    clkEn && pcLoad |=> pc[0] == 1'b0 && pc[25:1] == $past(pcTarget[25:1]))
    else $error("Program counter load not even or wrong");

  a_pc_carry_drop: assert property ( // [RULE6]
    @(posedge core_clk) disable iff (srst)
    clkEn && !pcLoad && pcAdv
    |=> pc[25:1] == 25'($past(pc[25:1]) + $past(pcStep[25:1]))
        && pc[31:26] == 6'h00)
    else $error("Program counter advance wrong or carry leaked");

  a_ep_mirror: assert property ( // [RULE4]
    @(posedge core_clk) disable iff (srst)
    epBase == gpr[`CPRS_EP_IDX])
    else $error("Element pointer copy out of step");

  a_zero_read_b: assert property ( // [RULE3]
    @(posedge core_clk) disable iff (srst)
    clkEn && rdAddrB == `CPRS_ZERO_IDX |=> rdDataB == '0)
    else $error("Register zero read nonzero on port B");

  a_gpr_read_b: assert property ( // [RULE1]
    @(posedge core_clk) disable iff (srst)
    clkEn && rdAddrB != `CPRS_ZERO_IDX && !(wrEn && wrAddr == rdAddrB)
    |=> rdDataB == $past(gpr[rdAddrB]))
    else $error("Port B read not the stored word");

  a_short_hold: assert property ( // [RULE4]
    @(posedge core_clk) disable iff (srst)
    !(clkEn && shortAccess) |=> $stable(shortAddr))
    else $error("Short access address moved without a strobe");

  a_pc_freeze: assert property ( // [RULE5]
    @(posedge core_clk) disable iff (srst)
    !clkEn |=> $stable(pc))
    else $error("Program counter moved while frozen");

  a_pc_even: assert property ( // [RULE7]
    @(posedge core_clk) disable iff (srst)
    pc[0] == 1'b0)
    else $error("Program counter bit zero set");

endmodule

//--- bench/cprs_pipe_model.sv
`timescale 1ns/1ps
////////////////////////////////////////////////////////////////////
// Pipeline stand-in. Requests change 1 ns after the rising edge and
// hold through the edge that takes them.
module cprs_pipe_model (
  input  wire logic           core_clk,    // Core clock
  output logic                clkEn,       // Run enable
  output cprs_pkg::cprs_idx_t  rdAddrA,     // Read A index
  output cprs_pkg::cprs_idx_t  rdAddrB,     // Read B index
  output logic                wrEn,        // Write strobe
  output cprs_pkg::cprs_idx_t  wrAddr,      // Write index
  output cprs_pkg::cprs_word_t wrData,      // Write value
  output logic                shortAccess, // Short strobe
  output logic [7:0]          shortDisp,   // Displacement
  output logic                pcLoad,      // Branch
  output cprs_pkg::cprs_word_t pcTarget,    // Branch target
  output logic                pcAdv,       // Advance
  output cprs_pkg::cprs_word_t pcStep,      // Advance amount
  output logic                debugMode,   // Debug window
  output logic                srWrEn,      // Sysreg load
  output cprs_pkg::cprs_idx_t  srWrNum,     // Sysreg number
  output cprs_pkg::cprs_word_t srWrData,    // Sysreg value
  output logic                srRdEn,      // Sysreg store
  output cprs_pkg::cprs_idx_t  srRdNum,     // Sysreg number
  output logic                causeLoadEn, // Cause capture
  output cprs_pkg::cprs_word_t causeLoadVal // Cause code
);
  import cprs_pkg::*;

  // Unqualified data lines are scrambled, never left at the old value
  task automatic clear();
    clkEn = 1'b1;
    wrEn = 1'b0;
    shortAccess = 1'b0;
    pcLoad = 1'b0;
    pcAdv = 1'b0;
    srWrEn = 1'b0;
    srRdEn = 1'b0;
    causeLoadEn = 1'b0;
    wrData = ~wrData;
    shortDisp = ~shortDisp;
    pcTarget = ~pcTarget;
    pcStep = ~pcStep;
    srWrData = ~srWrData;
    causeLoadVal = ~causeLoadVal;
  endtask

  task automatic tick();
    @(posedge core_clk);
    #1;
    clear();
  endtask

  initial begin
    {rdAddrA, rdAddrB, wrAddr, srWrNum, srRdNum} = '0;
    {wrData, pcTarget, pcStep, srWrData, causeLoadVal} = '0;
    shortDisp = 8'h00;
    debugMode = 1'b0;
    clear();
  end
endmodule

//--- bench/testbench.sv
`timescale 1ns/1ps
module testbench;
  import cprs_pkg::*;
  logic        core_clk = 1'b0;
  logic        srst = 1'b1;
  logic        clkEn, wrEn, shortAccess, pcLoad, pcAdv, debugMode;
  logic        srWrEn, srRdEn, causeLoadEn, intAckHold;
  logic [7:0]  shortDisp;
  cprs_idx_t   rdAddrA, rdAddrB, wrAddr, srWrNum, srRdNum;
  cprs_word_t  wrData, pcTarget, pcStep, srWrData, causeLoadVal;
  cprs_word_t  rdDataA, rdDataB, shortAddr, epBase, pc, srRdData;
  cprs_word_t  statusWord;
  int          miscompares = 0;
  int          totalChecks = 0;
  int          cycles = 0;
  int          n;
  logic [15:0] seed = 16'h6549;
  logic [31:0] gm [32];
  logic [31:0] sm [32];
  logic [31:0] pcm, r, expA, expB;
  int          srList [$] = '{0, 1, 2, 3, 5, 16, 17, 18, 19, 20};

  always #20 core_clk = ~core_clk;

  cprs_pipe_model pipe (.core_clk, .clkEn, .rdAddrA, .rdAddrB, .wrEn,
    .wrAddr, .wrData, .shortAccess, .shortDisp, .pcLoad, .pcTarget, .pcAdv,
    .pcStep, .debugMode, .srWrEn, .srWrNum, .srWrData, .srRdEn, .srRdNum,
    .causeLoadEn, .causeLoadVal);

  cprs_regs dut (.core_clk, .srst, .clkEn, .rdAddrA, .rdDataA, .rdAddrB,
    .rdDataB, .wrEn, .wrAddr, .wrData, .shortAccess, .shortDisp, .shortAddr,
    .epBase, .pcLoad, .pcTarget, .pcAdv, .pcStep, .pc, .debugMode, .srWrEn,
    .srWrNum, .srWrData, .srRdEn, .srRdNum, .srRdData, .causeLoadEn,
    .causeLoadVal, .statusWord, .intAckHold);

  ////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] rnd();
    logic [31:0] v;
    v = '0;
    for (int i = 0; i < 32; i++) begin
      seed = {seed[14:0], seed[15] ^ seed[13] ^ seed[12] ^ seed[10]};
      v = {v[30:0], seed[0]};
    end
    return v;
  endfunction

  function automatic logic [31:0] srMask(input int k);
    if (k inside {0, 2, 16, 18}) return 32'h03FF_FFFF;
    if (k inside {1, 3, 5, 17, 19}) return 32'h0000_00FF;
    if (k == 20) return 32'hFFFF_FFFF;
    return 32'h0000_0000;
  endfunction

  task automatic chk(input string name, input logic [31:0] seen,
                     input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic stopTest();
    if (miscompares == 0 && totalChecks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Run needs about 125 cycles; a hang is cut well beyond that
  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 1000) begin
      miscompares++;
      stopTest();
    end
  end

  ////////////////////////////////////////////////////////////////////
  initial begin
    for (int i = 0; i < 32; i++) begin
      gm[i] = '0;
      sm[i] = '0;
    end
    sm[5] = 32'h0000_0020;
    pcm = '0;
    expA = '0;
    expB = '0;
    repeat (10) @(posedge core_clk);
    #1;
    srst = 1'b0;
    chk("pc", pc, pcm);
    chk("statusWord", statusWord, sm[5]);
    // Random traffic, index 0 first, with frozen cycles mixed in
    for (int k = 0; k < 40; k++) begin
      r = rnd();
      pipe.clkEn = (k % 8 != 7);
      pipe.wrEn = (k < 3) | r[10];
      pipe.wrAddr = (k < 3) ? 5'h00 : r[4:0];
      pipe.wrData = rnd();
      pipe.rdAddrA = pipe.wrAddr;
      pipe.rdAddrB = r[9:5];
      if (pipe.clkEn) begin
        if (pipe.wrEn && pipe.wrAddr != 5'h00) gm[pipe.wrAddr] = pipe.wrData;
        expA = gm[pipe.rdAddrA];
        expB = gm[pipe.rdAddrB];
      end
      pipe.tick();
      chk("rdDataA", rdDataA, expA);
      chk("rdDataB", rdDataB, expB);
    end
    // Short access base is the element pointer before this write
    for (int k = 0; k < 8; k++) begin
      r = rnd();
      pipe.wrEn = 1'b1;
      pipe.wrAddr = 5'h1E;
      pipe.wrData = r;
      pipe.shortAccess = 1'b1;
      pipe.shortDisp = r[15:8];
      pipe.tick();
      chk("shortAddr", shortAddr, gm[30] + {24'h00_0000, r[15:8]});
      gm[30] = r;
      pipe.tick();
      chk("epBase", epBase, gm[30]);
    end
    // Load beats advance; all-ones target leaves only bits 25:1
    pipe.pcLoad = 1'b1;
    pipe.pcTarget = 32'hFFFF_FFFF;
    pipe.pcAdv = 1'b1;
    pipe.pcStep = 32'h0000_0004;
    pipe.tick();
    pcm = 32'h03FF_FFFE;
    chk("pc", pc, pcm);
    pipe.pcAdv = 1'b1;
    pipe.pcStep = 32'h0000_0002;
    pipe.tick();
    pcm = 32'h0000_0000;
    chk("pc", pc, pcm);
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      pipe.pcLoad = r[0];
      pipe.pcAdv = ~r[0];
      pipe.pcTarget = rnd();
      pipe.pcStep = rnd();
      pcm = r[0] ? pipe.pcTarget : pcm + pipe.pcStep;
      pcm = pcm & 32'h03FF_FFFE;
      pipe.tick();
      chk("pc", pc, pcm);
    end
    // Frozen edge: advance and status load both held off
    pipe.clkEn = 1'b0;
    pipe.pcAdv = 1'b1;
    pipe.pcStep = 32'h0000_0004;
    pipe.srWrEn = 1'b1;
    pipe.srWrNum = 5'h05;
    pipe.srWrData = rnd();
    pipe.tick();
    chk("pc", pc, pcm);
    chk("statusWord", statusWord, sm[5]);
    chk("intAckHold", {31'h0, intAckHold}, 32'h0);
    // Every defined number except cause (4), outside and inside the debug window
    for (int p = 0; p < 2; p++) begin
      foreach (srList[i]) begin
        n = srList[i];
        r = rnd();
        pipe.debugMode = p[0];
        pipe.srWrEn = 1'b1;
        pipe.srWrNum = n[4:0];
        pipe.srWrData = r;
        if (p == 1 || !(n inside {18, 19})) sm[n] = r & srMask(n);
        pipe.tick();
        chk("intAckHold", {31'h0, intAckHold}, {31'h0, n == 5});
        chk("statusWord", statusWord, sm[5]);
        pipe.srRdEn = 1'b1;
        pipe.srRdNum = n[4:0];
        pipe.tick();
        expA = (p == 0 && n inside {18, 19}) ? 32'h0 : sm[n];
        chk("srRdData", srRdData, expA);
        chk("intAckHold", {31'h0, intAckHold}, 32'h0);
      end
    end
    // Cause register: hardware capture lands, software load is dropped
    r = rnd();
    pipe.causeLoadEn = 1'b1;
    pipe.causeLoadVal = r;
    pipe.tick();
    pipe.srWrEn = 1'b1;
    pipe.srWrNum = 5'h04;
    pipe.srWrData = ~r;
    pipe.srRdEn = 1'b1;
    pipe.srRdNum = 5'h04;
    pipe.tick();
    chk("srRdData", srRdData, r);
    pipe.srRdEn = 1'b1;
    pipe.tick();
    chk("srRdData", srRdData, r);
    stopTest();
  end
endmodule
